/* common/ircp_defines.svh */
// constants for the remote command port: codes, bit positions, sizes
`ifndef IRCP_DEFINES_SVH
`define IRCP_DEFINES_SVH

// bus commands, seven-bit codes and two-bit address group prefixes sent with attention asserted
`define IRCP_CMD_DCL     7'h14
`define IRCP_CMD_SDC     7'h04
`define IRCP_CMD_SPE     7'h18
`define IRCP_CMD_SPD     7'h19
`define IRCP_CMD_UNL     7'h3F
`define IRCP_CMD_UNT     7'h5F
`define IRCP_GRP_LISTEN  2'h1
`define IRCP_GRP_TALK    2'h2

// characters seen by the command parser
`define IRCP_CH_SEMI     7'h3B
`define IRCP_CH_LF       7'h0A
`define IRCP_CH_O        7'h4F
`define IRCP_CH_U        7'h55
`define IRCP_CH_DIGIT_HI 3'h3
`define IRCP_CH_NINE     4'h9
`define IRCP_CH_OU_DIGIT 5'h0C
`define IRCP_CH_UPPER    2'h2

// serial poll status byte and parallel poll line
`define IRCP_STB_READY   4
`define IRCP_STB_ERR     5
`define IRCP_STB_RQS     6
`define IRCP_PP_LINE     0

// output queue: one data byte plus an end flag, eight entries
`define IRCP_FIFO_WIDTH  9
`define IRCP_FIFO_DEPTH  8

`endif

/* common/ircp_pkg.sv */
// types shared by the remote command port
package ircp_pkg;

    typedef enum logic {IRCP_SRQ_MASKED, IRCP_SRQ_ON_DATA} ircp_srq_mode_t;

    typedef enum logic {IRCP_HOLDOFF, IRCP_EARLY} ircp_hs_mode_t;

    typedef enum logic {IRCP_AH_IDLE, IRCP_AH_ACCEPT} ircp_ah_state_t;

    typedef enum logic [1:0] {
        IRCP_SH_IDLE,
        IRCP_SH_READY,
        IRCP_SH_DAV
    } ircp_sh_state_t;

endpackage

/* design/ircp_fifo.sv */
// output queue between instrument results and the bus talker
`timescale 1ns/1ps
`default_nettype none
`include "ircp_defines.svh"

module ircp_fifo #(
    parameter int WIDTH = `IRCP_FIFO_WIDTH,
    parameter int DEPTH = `IRCP_FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (i_flush) begin
            next_count = '0;
        end else if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
            o_in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count      <= next_count;
            // registered so the instrument side sees a clean ready
            o_in_ready <= (next_count < (AW+1)'(DEPTH));
        end
    end

endmodule // ircp_fifo
`default_nettype wire

/* design/ircp_port.sv */
// remote command port: bus handshakes, addressing, parser, status
`timescale 1ns/1ps
`default_nettype none
`include "ircp_defines.svh"

module ircp_port (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic [4:0] i_bus_addr,
    input  wire logic [7:0] i_dio_n,
    output logic      [7:0] o_dio_n,
    output logic      [7:0] o_dio_oe,
    input  wire logic       i_dav_n,
    output logic            o_dav_n,
    output logic            o_dav_oe,
    input  wire logic       i_nrfd_n,
    output logic            o_nrfd_n,
    output logic            o_nrfd_oe,
    input  wire logic       i_ndac_n,
    output logic            o_ndac_n,
    output logic            o_ndac_oe,
    input  wire logic       i_eoi_n,
    output logic            o_eoi_n,
    output logic            o_eoi_oe,
    output logic            o_srq_n,
    output logic            o_srq_oe,
    input  wire logic       i_atn_n,
    input  wire logic       i_ifc_n,
    input  wire logic       i_ren_n,
    input  wire logic       i_talk_only,
    input  wire logic       i_output_key,
    input  wire logic       i_res_valid,
    input  wire logic [7:0] i_res_data,
    input  wire logic       i_res_last,
    output logic            o_res_ready,
    input  wire logic       i_cmds_accepted,
    input  wire logic       i_error,
    output logic            o_key_valid,
    output logic      [7:0] o_key_code,
    output logic            o_image_req,
    output logic            o_remote,
    output logic            o_legacy_mode,
    output logic            o_srq_mode,
    output logic            o_holdoff_mode,
    output logic            o_dev_clear,
    output logic            o_talk,
    output logic            o_listen
);
    ircp_pkg::ircp_ah_state_t ah_state;
    ircp_pkg::ircp_ah_state_t next_ah;
    ircp_pkg::ircp_sh_state_t sh_state;
    ircp_pkg::ircp_srq_mode_t srq_mode;
    ircp_pkg::ircp_hs_mode_t  hs_mode;

    logic       pin_low;
    logic       atn;
    logic       ifc;
    logic       ah_on;
    logic       take;
    logic       listen;
    logic       talk;
    logic       spoll;
    logic       hold;
    logic       rx_strobe;
    logic       rx_atn;
    logic [6:0] rx_byte;
    logic       rx_cmd;
    logic       rx_data;
    logic       clr;
    logic [6:0] c0;
    logic [6:0] c1;
    logic [6:0] c2;
    logic [1:0] cnt;
    logic       legacy;
    logic       err;
    logic       srq;
    logic       ready;
    logic       talk_en;
    logic       spoll_sel;
    logic       pp;
    logic       fifo_valid;
    logic [8:0] fifo_data;
    logic       fifo_pop;
    logic [7:0] stb;

    assign atn       = ~i_atn_n;
    assign ifc       = ~i_ifc_n;
    assign ah_on     = atn | listen;
    assign take      = (ah_state == ircp_pkg::IRCP_AH_IDLE) && ah_on
                       && !hold && !i_dav_n;
    assign rx_cmd    = rx_strobe && rx_atn;
    assign rx_data   = rx_strobe && !rx_atn && listen;
    assign clr       = rx_cmd && (rx_byte == `IRCP_CMD_DCL
                       || (rx_byte == `IRCP_CMD_SDC && listen));
    assign talk_en   = (talk | i_talk_only) & ~atn;
    assign spoll_sel = spoll & talk;
    assign pp        = atn & ~i_eoi_n;
    assign fifo_pop  = (sh_state == ircp_pkg::IRCP_SH_DAV) && talk_en
                       && i_ndac_n && !spoll_sel;

    always_comb begin
        stb                 = 8'h00;
        stb[`IRCP_STB_RQS]   = srq;
        stb[`IRCP_STB_ERR]   = err;
        stb[`IRCP_STB_READY] = ready;
    end

    ////////////////////////////////////////////////////////////////////
    // output queue
    ircp_fifo #(
        .WIDTH (`IRCP_FIFO_WIDTH),
        .DEPTH (`IRCP_FIFO_DEPTH)
    ) u_queue (
        .i_clk       (i_ref_clk),
        .i_rst       (i_rst),
        .i_flush     (clr),
        .i_in_valid  (i_res_valid),
        .i_in_data   ({i_res_last, i_res_data}),
        .o_in_ready  (o_res_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////
    // acceptor handshake
    always_comb begin
        next_ah = ah_state;
        unique case (ah_state)
            ircp_pkg::IRCP_AH_IDLE:   if (take) begin
                next_ah = ircp_pkg::IRCP_AH_ACCEPT;
            end
            ircp_pkg::IRCP_AH_ACCEPT: if (i_dav_n) begin
                next_ah = ircp_pkg::IRCP_AH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || ifc) begin
            ah_state  <= ircp_pkg::IRCP_AH_IDLE;
            o_nrfd_oe <= 1'b0;
            o_ndac_oe <= 1'b0;
            rx_strobe <= 1'b0;
            rx_atn    <= 1'b0;
            rx_byte   <= 7'h00;
        end else begin
            ah_state  <= next_ah;
            // not ready while holding or while a byte is in flight
            o_nrfd_oe <= ah_on && (hold || !i_dav_n
                         || next_ah == ircp_pkg::IRCP_AH_ACCEPT);
            o_ndac_oe <= ah_on && (next_ah != ircp_pkg::IRCP_AH_ACCEPT);
            rx_strobe <= take;
            if (take) begin
                rx_atn  <= atn;
                rx_byte <= ~i_dio_n[6:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            hold <= 1'b0;
        end else if (take && !atn && listen
                     && ~i_dio_n[6:0] == `IRCP_CH_LF
                     && hs_mode == ircp_pkg::IRCP_HOLDOFF) begin
            hold <= 1'b1;
        end else if (i_cmds_accepted || ifc || clr) begin
            hold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // addressing and bus commands
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || ifc) begin
            listen <= 1'b0;
            talk   <= 1'b0;
            spoll  <= 1'b0;
        end else if (rx_cmd) begin
            if (rx_byte == {`IRCP_GRP_LISTEN, i_bus_addr}) begin
                listen <= 1'b1;
            end else if (rx_byte == `IRCP_CMD_UNL) begin
                listen <= 1'b0;
            end
            // another talk address unaddresses this one
            if (rx_byte[6:5] == `IRCP_GRP_TALK) begin
                talk <= (rx_byte[4:0] == i_bus_addr);
                // own talk address ends listening, no self echo
                if (rx_byte[4:0] == i_bus_addr) begin
                    listen <= 1'b0;
                end
            end
            if (rx_byte == `IRCP_CMD_SPE) begin
                spoll <= 1'b1;
            end else if (rx_byte == `IRCP_CMD_SPD) begin
                spoll <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command parser and keystroke output
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            c0       <= 7'h00;
            c1       <= 7'h00;
            c2       <= 7'h00;
            cnt      <= 2'h0;
            legacy   <= 1'b0;
            srq_mode <= ircp_pkg::IRCP_SRQ_MASKED;
            hs_mode  <= ircp_pkg::IRCP_HOLDOFF;
        end else if (clr && rx_byte == `IRCP_CMD_SDC) begin
            legacy <= 1'b0;
            cnt    <= 2'h0;
        end else if (rx_data) begin
            if (rx_byte == `IRCP_CH_SEMI) begin
                cnt    <= 2'h0;
                legacy <= 1'b0;
                if (cnt == 2'h3 && c2 == `IRCP_CH_O && c1 == `IRCP_CH_U
                    && c0[6:2] == `IRCP_CH_OU_DIGIT) begin
                    unique case (c0[1:0])
                        2'h0: srq_mode <= ircp_pkg::IRCP_SRQ_MASKED;
                        2'h1: srq_mode <= ircp_pkg::IRCP_SRQ_ON_DATA;
                        2'h2: hs_mode  <= ircp_pkg::IRCP_HOLDOFF;
                        2'h3: hs_mode  <= ircp_pkg::IRCP_EARLY;
                    endcase
                end
            end else begin
                // letter then digit with no semicolon after it
                if (cnt == 2'h2 && c1[6:5] == `IRCP_CH_UPPER
                    && c0[6:4] == `IRCP_CH_DIGIT_HI
                    && c0[3:0] <= `IRCP_CH_NINE) begin
                    legacy <= 1'b1;
                end
                c2  <= c1;
                c1  <= c0;
                c0  <= rx_byte;
                cnt <= (rx_byte == `IRCP_CH_LF) ? 2'h0
                       : (cnt == 2'h3) ? cnt : cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_key_valid <= 1'b0;
            o_key_code  <= 8'h00;
        end else begin
            o_key_valid <= rx_data;
            if (rx_data) begin
                o_key_code <= {1'b0, rx_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status, service request and device clear
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || clr) begin
            err   <= 1'b0;
            ready <= 1'b0;
            srq   <= 1'b0;
        end else begin
            if (i_error) begin
                err <= 1'b1;
            end
            ready <= fifo_valid;
            if (srq_mode == ircp_pkg::IRCP_SRQ_MASKED) begin
                srq <= 1'b0;
            end else if (fifo_valid) begin
                srq <= 1'b1;
            end else if (!err) begin
                srq <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pin_low        <= 1'b0;
            o_srq_oe       <= 1'b0;
            o_dev_clear    <= 1'b0;
            o_image_req    <= 1'b0;
            o_remote       <= 1'b0;
            o_legacy_mode  <= 1'b0;
            o_srq_mode     <= 1'b0;
            o_holdoff_mode <= 1'b1;
            o_talk         <= 1'b0;
            o_listen       <= 1'b0;
        end else begin
            pin_low        <= 1'b0;
            o_srq_oe       <= srq;
            o_dev_clear    <= clr;
            o_image_req    <= i_output_key & i_talk_only;
            o_remote       <= ~i_ren_n;
            o_legacy_mode  <= legacy;
            o_srq_mode     <= (srq_mode == ircp_pkg::IRCP_SRQ_ON_DATA);
            o_holdoff_mode <= (hs_mode == ircp_pkg::IRCP_HOLDOFF);
            o_talk         <= talk;
            o_listen       <= listen;
        end
    end

    assign o_nrfd_n = pin_low;
    assign o_ndac_n = pin_low;
    assign o_srq_n  = pin_low;

    ////////////////////////////////////////////////////////////////////
    // source handshake, data lines and end line
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || ifc || !talk_en) begin
            sh_state <= ircp_pkg::IRCP_SH_IDLE;
            o_dav_oe <= 1'b0;
        end else begin
            unique case (sh_state)
                ircp_pkg::IRCP_SH_IDLE: if (spoll_sel || fifo_valid) begin
                    sh_state <= ircp_pkg::IRCP_SH_READY;
                end
                ircp_pkg::IRCP_SH_READY: if (i_nrfd_n) begin
                    sh_state <= ircp_pkg::IRCP_SH_DAV;
                    o_dav_oe <= 1'b1;
                end
                ircp_pkg::IRCP_SH_DAV: if (i_ndac_n) begin
                    sh_state <= ircp_pkg::IRCP_SH_IDLE;
                    o_dav_oe <= 1'b0;
                end
                default: sh_state <= ircp_pkg::IRCP_SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || ifc) begin
            o_dio_n  <= 8'hFF;
            o_dio_oe <= 8'h00;
            o_eoi_oe <= 1'b0;
        end else if (pp) begin
            o_dio_n  <= 8'h00;
            o_dio_oe <= srq ? (8'h01 << `IRCP_PP_LINE) : 8'h00;
            o_eoi_oe <= 1'b0;
        end else if (!talk_en) begin
            o_dio_oe <= 8'h00;
            o_eoi_oe <= 1'b0;
        end else if (fifo_pop) begin
            // end line dropped with the byte, or it reads as a poll
            o_eoi_oe <= 1'b0;
        end else if (sh_state == ircp_pkg::IRCP_SH_IDLE
                     && (spoll_sel || fifo_valid)) begin
            o_dio_n  <= spoll_sel ? ~stb : ~fifo_data[7:0];
            o_dio_oe <= 8'hFF;
            o_eoi_oe <= !spoll_sel && fifo_data[8];
        end
    end

    assign o_dav_n = pin_low;
    assign o_eoi_n = pin_low;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_ifc_drops_addr: assert property (ifc |=> !listen && !talk)
        else $error("addressing survived interface clear");
    a_masked_no_srq: assert property (
        srq_mode == ircp_pkg::IRCP_SRQ_MASKED |=> ##1 !o_srq_oe)
        else $error("service request raised in masked mode");
    a_data_srq: assert property (
        srq_mode == ircp_pkg::IRCP_SRQ_ON_DATA && fifo_valid && !clr
        |=> srq ##1 o_srq_oe)
        else $error("no service request with data queued");
    a_empty_clears: assert property (
        srq_mode == ircp_pkg::IRCP_SRQ_ON_DATA && !fifo_valid && !err
        && !i_error |=> !srq && !ready)
        else $error("request or ready left set on empty queue");
    a_hold_stalls: assert property (
        hold && ah_on && !ifc |=> o_nrfd_oe)
        else $error("handshake released during hold-off");
    a_early_no_hold: assert property (
        hs_mode == ircp_pkg::IRCP_EARLY && !hold |=> !hold)
        else $error("hold-off taken in early mode");
    a_atn_stops_talk: assert property (atn |=> !o_dav_oe)
        else $error("data valid driven under attention");
    a_dav_after_nrfd: assert property (
        $rose(o_dav_oe) |-> $past(i_nrfd_n) && o_dio_oe == 8'hFF)
        else $error("data valid before listeners ready");
    a_semi_exit: assert property (
        rx_data && rx_byte == `IRCP_CH_SEMI |=> !legacy ##1 !o_legacy_mode)
        else $error("legacy mode kept after semicolon");
    a_key_forward: assert property (rx_data |=> o_key_valid)
        else $error("received character not forwarded");
    a_remote_follows: assert property (!i_ren_n [*2] |-> o_remote)
        else $error("remote state not following enable");

    c_legacy_entry: cover property ($rose(legacy));
    c_srq_raised:   cover property ($rose(o_srq_oe));
    c_hold_done:    cover property (hold ##[1:50] !hold);
    c_byte_sent:    cover property (fifo_pop);

endmodule // ircp_port
`default_nettype wire

/* verification/ircp_ctrl_model.sv */
// bus controller and printer model: source and acceptor handshakes
`timescale 1ns/1ps
`default_nettype none

module ircp_ctrl_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_dio_n,
    input  wire logic       i_dav_n,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    input  wire logic       i_eoi_n,
    output logic      [7:0] o_c_dio_n,
    output logic            o_c_dav_n,
    output logic            o_c_nrfd_n,
    output logic            o_c_ndac_n,
    output logic            o_c_eoi_n,
    output logic            o_c_atn_n
);
    int n;
    logic [7:0] stall_count = 8'h00;

    // idle: listening with NRFD and NDAC held low, other lines released
    initial begin
        o_c_dio_n  = 8'hFF;
        o_c_dav_n  = 1'b1;
        o_c_nrfd_n = 1'b0;
        o_c_ndac_n = 1'b0;
        o_c_atn_n  = 1'b1;
        o_c_eoi_n  = 1'b1;
    end

    task automatic tick();
        @(posedge i_ref_clk);
        #1;
        n++;
        if (n == 500) stall_count++;
    endtask

    // parallel poll: attention with end line, read the data lines
    task automatic poll(output logic [7:0] b);
        n = 0;
        tick();
        o_c_atn_n = 1'b0;
        o_c_eoi_n = 1'b0;
        tick();
        b = ~i_dio_n;
        o_c_eoi_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // source: byte is a command while atn is set
    task automatic send(input logic [7:0] b, input logic atn);
        n = 0;
        tick();
        o_c_atn_n  = ~atn;
        o_c_dio_n  = ~b;
        o_c_nrfd_n = 1'b1;
        o_c_ndac_n = 1'b1;
        tick();
        while (!i_nrfd_n && n < 500) tick();
        o_c_dav_n = 1'b0;
        while (!i_ndac_n && n < 500) tick();
        o_c_dav_n  = 1'b1;
        o_c_dio_n  = 8'hFF;
        o_c_nrfd_n = 1'b0;
        o_c_ndac_n = 1'b0;
    endtask

    // acceptor: listens whenever asked, as a printer would
    task automatic recv(output logic [7:0] b, output logic e);
        n = 0;
        tick();
        o_c_atn_n  = 1'b1;
        o_c_nrfd_n = 1'b1;
        while (i_dav_n && n < 500) tick();
        b = ~i_dio_n;
        e = ~i_eoi_n;
        o_c_nrfd_n = 1'b0;
        o_c_ndac_n = 1'b1;
        while (!i_dav_n && n < 500) tick();
        o_c_ndac_n = 1'b0;
    endtask
endmodule // ircp_ctrl_model

`default_nettype wire

/* verification/ircp_port_tb.sv */
// self-checking bench for the remote command port
`timescale 1ns/1ps
`default_nettype none
`include "ircp_defines.svh"

module ircp_port_tb;
    localparam logic [4:0] ADDR = 5'h0A;
    logic       i_ref_clk = 1'b0;
    logic       i_rst, i_ifc_n, i_ren_n, i_talk_only, i_output_key;
    logic       i_res_valid, i_res_last, i_cmds_accepted, i_error;
    logic [7:0] i_res_data, o_dio_n, o_dio_oe, o_key_code, o_c_dio_n;
    logic [7:0] key, b;
    logic       o_dav_n, o_dav_oe, o_nrfd_n, o_nrfd_oe, o_ndac_n;
    logic       o_ndac_oe, o_eoi_n, o_eoi_oe, o_srq_n, o_srq_oe;
    logic       o_res_ready, o_key_valid, o_image_req, o_remote;
    logic       o_legacy_mode, o_srq_mode, o_holdoff_mode, o_dev_clear;
    logic       o_talk, o_listen, img, dcl, e;
    logic       o_c_dav_n, o_c_nrfd_n, o_c_ndac_n, o_c_atn_n, o_c_eoi_n;
    wire  [4:0] i_bus_addr = ADDR;
    wire  [7:0] i_dio_n    = o_c_dio_n & (o_dio_n | ~o_dio_oe);
    wire        i_dav_n    = o_c_dav_n & (o_dav_n | ~o_dav_oe);
    wire        i_nrfd_n   = o_c_nrfd_n & (o_nrfd_n | ~o_nrfd_oe);
    wire        i_ndac_n   = o_c_ndac_n & (o_ndac_n | ~o_ndac_oe);
    wire        i_eoi_n    = o_c_eoi_n & (o_eoi_n | ~o_eoi_oe);
    wire        i_atn_n    = o_c_atn_n;
    int         fail_count = 0;
    int         check_count = 0;

    ircp_port DUT (.*);
    ircp_ctrl_model M (.*);

    always #10 i_ref_clk = ~i_ref_clk;

    // catch one-cycle pulses
    always @(posedge i_ref_clk) begin
        if (o_key_valid === 1'b1) key = o_key_code;
        if (o_image_req === 1'b1) img = 1'b1;
        if (o_dev_clear === 1'b1) dcl = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic str(input string s);
        foreach (s[i]) M.send(s[i], 1'b0);
        cyc(4);
    endtask

    task automatic push(input logic [7:0] d);
        i_res_data  = d;
        i_res_last  = 1'b1;
        i_res_valid = 1'b1;
        cyc(1);
        i_res_valid = 1'b0;
        cyc(4);
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end

    initial begin
        {i_rst, i_ifc_n, i_ren_n} = 3'h7;
        {i_talk_only, i_output_key, i_res_valid, i_res_last} = 4'h0;
        {i_cmds_accepted, i_error, img, dcl} = 4'h0;
        i_res_data = 8'h00;
        key = 8'h00;
        cyc(5);
        i_rst = 1'b0;
        chk(o_holdoff_mode, 1'h1);
        chk(o_srq_mode, 1'h0);
        chk(o_res_ready, 1'h0);
        i_ren_n = 1'b0;
        cyc(2);
        chk(o_remote, 1'h1);
        M.send({1'b0, `IRCP_GRP_LISTEN, ADDR}, 1'b1);
        str("\xC1");
        chk(o_listen, 1'h1);
        chk(key, 8'h41);
        push(8'h35);
        chk(o_srq_oe, 1'h0);
        M.send({1'b0, `IRCP_CMD_SPE}, 1'b1);
        M.send({1'b0, `IRCP_GRP_TALK, ADDR}, 1'b1);
        M.recv(b, e);
        chk(b[`IRCP_STB_READY], 1'h1);
        M.send({1'b0, `IRCP_CMD_SPD}, 1'b1);
        M.recv(b, e);
        chk(b, 8'h35);
        chk(e, 1'h1);
        M.send({1'b0, `IRCP_CMD_UNT}, 1'b1);
        M.send({1'b0, `IRCP_GRP_LISTEN, ADDR}, 1'b1);
        str("OU1;");
        chk(o_srq_mode, 1'h1);
        push(8'h52);
        chk(o_srq_oe, 1'h1);
        M.send({1'b0, `IRCP_GRP_TALK, ADDR}, 1'b1);
        M.recv(b, e);
        cyc(4);
        chk(o_srq_oe, 1'h0);
        i_error = 1'b1;
        cyc(1);
        i_error = 1'b0;
        push(8'h52);
        M.recv(b, e);
        chk(b, 8'h52);
        cyc(4);
        chk(o_srq_oe, 1'h1);
        M.poll(b);
        chk(b, 8'h01);
        M.send({1'b0, `IRCP_GRP_LISTEN, ADDR}, 1'b1);
        str("OU0;");
        chk(o_srq_mode, 1'h0);
        chk(o_srq_oe, 1'h0);
        str("OU1;OU2;\n");
        chk(o_nrfd_oe, 1'h1);
        i_cmds_accepted = 1'b1;
        cyc(1);
        i_cmds_accepted = 1'b0;
        cyc(4);
        chk(o_nrfd_oe, 1'h0);
        str("OU3;\n");
        chk(o_nrfd_oe, 1'h0);
        chk(o_holdoff_mode, 1'h0);
        str("M8,");
        chk(o_legacy_mode, 1'h1);
        chk(o_srq_mode, 1'h1);
        str(";");
        chk(o_legacy_mode, 1'h0);
        str("M8,");
        M.send({1'b0, `IRCP_CMD_SDC}, 1'b1);
        cyc(4);
        chk(o_legacy_mode, 1'h0);
        chk(dcl, 1'h1);
        M.send({1'b0, `IRCP_CMD_DCL}, 1'b1);
        i_ifc_n = 1'b0;
        cyc(2);
        i_ifc_n = 1'b1;
        cyc(1);
        chk({o_talk, o_listen}, 2'h0);
        i_talk_only  = 1'b1;
        i_output_key = 1'b1;
        cyc(1);
        i_output_key = 1'b0;
        cyc(3);
        chk(img, 1'h1);
        repeat (8) push(8'h27);
        chk(o_res_ready, 1'h0);
        M.recv(b, e);
        chk(b, 8'h27);
        chk(o_res_ready, 1'h1);
        chk(M.stall_count, 8'h00);
        end_of_test();
    end
endmodule // ircp_port_tb

`default_nettype wire
